/* File: rtl/slave_board_bringup_loader.sv */
// Operation
// - sixteen boards share page, answer when selected
// - reset slave cannot grant; host waits
// - write 041h releases reset, maps top page
// - slave refreshes a word every 15 us
// - slave clears flag byte when initialised
// - slave polls flag, jumps on 0FFh
// - at most eight host cycles, then slave
`timescale 1ns/1ps
`default_nettype none
`include "slave_loader_regs.svh"
module slave_board_bringup_loader
    import slave_loader_pkg::*;
#(
    parameter logic [3:0] BOARD_ID = 4'h0,
    parameter int ADDR_WIDTH = 16,
    parameter int REFRESH_COUNT = `REFRESH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic host_io_wr,
    input wire logic host_io_addr,
    input wire logic [7:0] host_io_data,
    input wire logic host_mem_rd,
    input wire logic host_mem_wr,
    input wire logic [15:0] host_mem_addr,
    input wire logic [15:0] host_mem_wdata,
    output logic [15:0] host_mem_rdata,
    output logic host_ready,
    input wire logic slave_mem_rd,
    input wire logic slave_mem_wr,
    input wire logic [15:0] slave_mem_addr,
    input wire logic [15:0] slave_mem_wdata,
    output logic [15:0] slave_mem_rdata,
    output logic slave_grant,
    output logic slave_reset_n,
    output logic refresh_tick,
    output logic top_page_mapped
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] board_select;
    logic [7:0] board_info;
    logic [3:0] burst;
    logic [$clog2(REFRESH_COUNT+1)-1:0] refresh_cnt;
    logic host_read_pending;
    logic read_capture;
    arb_state_type state;
    arb_state_type next_state;

    function automatic logic port_hit(input logic wr, input logic a, input logic off);
        port_hit = wr && (a == off);
    endfunction

    wire selected = (board_select == BOARD_ID);
    wire select_wr = port_hit(host_io_wr, host_io_addr, `PORT_SELECT_OFFSET);
    wire info_wr = port_hit(host_io_wr, host_io_addr, `PORT_INFO_OFFSET) && selected;
    wire running = (board_info == `INFO_RUN_VALUE);
    wire host_req = (host_mem_rd || host_mem_wr) && selected;
    wire slave_req = slave_mem_rd || slave_mem_wr;
    wire burst_full = (burst >= `HOST_BURST_MAX);
    // a halted or reset slave grants nothing, so the host waits
    wire host_may_go = running && !burst_full;
    wire host_go = (state == arb_host);
    wire slave_go = (state == arb_slave);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            board_select <= `SELECT_RESET;
            board_info <= `INFO_RESET;
        end
        else
        begin
            if (select_wr)
                board_select <= host_io_data[3:0];
            if (info_wr)
                board_info <= host_io_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state = arb_idle;
        case (state)
            // after a host cycle the host request still stands; hand over instead of retaking it
            arb_host:
            begin
                if (slave_req && running)
                    next_state = arb_slave;
                else
                    next_state = arb_idle;
            end
            arb_idle, arb_slave:
            begin
                if (host_req && host_may_go)
                    next_state = arb_host;
                else if (slave_req && running)
                    next_state = arb_slave;
                else
                    next_state = arb_idle;
            end
            default:
                next_state = arb_idle;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state <= arb_idle;
            burst <= 4'h0;
            host_read_pending <= 1'b0;
            read_capture <= 1'b0;
        end
        else
        begin
            state <= next_state;
            host_read_pending <= (next_state == arb_host) && host_mem_rd;
            // dram read register fills one cycle after the host cycle
            read_capture <= host_read_pending;
            // burst clears only when the slave gets a cycle or the host idles
            if (next_state == arb_host)
                burst <= burst + 4'h1;
            else if (next_state == arb_slave || !host_req)
                burst <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !running)
        begin
            refresh_cnt <= '0;
            refresh_tick <= 1'b0;
        end
        else if (refresh_cnt == $bits(refresh_cnt)'(REFRESH_COUNT - 1))
        begin
            refresh_cnt <= '0;
            refresh_tick <= 1'b1;
        end
        else
        begin
            refresh_cnt <= refresh_cnt + 1'b1;
            refresh_tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host and slave both address the same 64K words directly, with no top-page offset
    wire [ADDR_WIDTH-1:0] mem_addr = host_go ? host_mem_addr : slave_mem_addr;
    wire [15:0] mem_wdata = host_go ? host_mem_wdata : slave_mem_wdata;
    wire mem_wr = (host_go && host_mem_wr) || (slave_go && slave_mem_wr);
    wire mem_rd = host_go || slave_go;
    logic [15:0] mem_rdata;

    slave_dram #(
        .ADDR_WIDTH(ADDR_WIDTH),
        .DATA_WIDTH(16)
    ) dram (
        .sys_clk(sys_clk),
        .wr_en(mem_wr),
        .rd_en(mem_rd),
        .addr(mem_addr),
        .wr_data(mem_wdata),
        .rd_data(mem_rdata)
    );

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
            host_mem_rdata <= 16'h0000;
        else if (read_capture)
            host_mem_rdata <= mem_rdata;
    end

    assign slave_mem_rdata = mem_rdata;
    assign host_ready = host_go;
    assign slave_grant = slave_go;
    assign slave_reset_n = running;
    assign top_page_mapped = running;
endmodule
`default_nettype wire

/* File: rtl/slave_dram.sv */
`timescale 1ns/1ps
`default_nettype none
// slave dram with registered read data
module slave_dram #(
    parameter int ADDR_WIDTH = 16,
    parameter int DATA_WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [DATA_WIDTH-1:0] wr_data,
    output logic [DATA_WIDTH-1:0] rd_data
);
    logic [DATA_WIDTH-1:0] mem [0:(1<<ADDR_WIDTH)-1];

    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
            mem[addr] <= wr_data;
        if (rd_en)
            rd_data <= mem[addr];
    end
endmodule
`default_nettype wire

/* File: rtl/slave_loader_pkg.sv */
package slave_loader_pkg;
    typedef enum logic [1:0] {
        arb_idle,
        arb_host,
        arb_slave
    } arb_state_type;
endpackage

/* File: rtl/slave_loader_regs.svh */
`ifndef SLAVE_LOADER_REGS_SVH
`define SLAVE_LOADER_REGS_SVH

// host i/o port offsets within the board's port pair
`define PORT_SELECT_OFFSET 1'h0
`define PORT_INFO_OFFSET 1'h1
// board info value that releases the slave reset and maps the top page
`define INFO_RUN_VALUE 8'h41
// reset values
`define SELECT_RESET 4'h0
`define INFO_RESET 8'h00
// slave page mapped under the host window when running
`define TOP_PAGE 4'hf
// host burst limit before a slave cycle is forced
`define HOST_BURST_MAX 4'h8
// refresh: one word at least every 15 us at a 100 ns clock
`define REFRESH_NS 15000
`define CLOCK_NS 100
`define REFRESH_CYCLES (`REFRESH_NS / `CLOCK_NS)

`endif

/* File: verification/host_bfm.sv */
`timescale 1ns/1ps
`default_nettype none
module host_bfm (
    input wire logic sys_clk, host_ready,
    output logic host_io_wr, host_io_addr, host_mem_rd, host_mem_wr,
    output logic [7:0] host_io_data,
    output logic [15:0] host_mem_addr, host_mem_wdata
);
    initial {host_io_wr, host_io_addr, host_io_data, host_mem_rd, host_mem_wr} = 0;
    initial {host_mem_addr, host_mem_wdata} = 0;
    task automatic pw(input logic a, input logic [7:0] v);
        @(posedge sys_clk) #1 {host_io_wr, host_io_addr, host_io_data} = {1'b1, a, v};
        @(posedge sys_clk) #1 host_io_wr = 0;
        host_io_data = ~v;
    endtask
    // holds the request for k taken cycles, gives up after a bounded wait
    task automatic mem(input logic w, input logic [15:0] a, v, input int k, output logic ok);
        int n = 0;
        int t = 0;
        @(posedge sys_clk) #1 {host_mem_wr, host_mem_rd, host_mem_addr, host_mem_wdata} = {w, !w, a, v};
        for (n = 0; n < 40 * k && t < k; n++)
            @(posedge sys_clk) t += int'(host_ready === 1'b1);
        ok = (t == k);
        #1 {host_mem_wr, host_mem_rd} = 2'b00;
        host_mem_wdata = ~v;
    endtask
endmodule
`default_nettype wire

/* File: verification/loader_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module loader_chk #(
    parameter int REFRESH_COUNT = 4
) (
    input wire logic sys_clk, reset_n, host_io_wr, host_io_addr, host_mem_rd, host_mem_wr,
    input wire logic host_ready, slave_mem_rd, slave_mem_wr, slave_grant, slave_reset_n,
    input wire logic refresh_tick, top_page_mapped,
    input wire logic [7:0] host_io_data
);
    logic [15:0] gap;
    logic seen;
    logic [3:0] hcnt;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence host_turn; host_ready ##1 !host_ready; endsequence
    sequence run_release; $rose(slave_reset_n); endsequence
    // host cycles since the slave last owned the bus or the host went idle
    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || slave_grant || !(host_mem_rd || host_mem_wr))
            hcnt <= 4'h0;
        else if (host_ready)
            hcnt <= hcnt + 4'h1;
    end
    // seen: a tick already came while the slave ran, so the gap is meaningful
    always_ff @(posedge sys_clk)
    begin
        gap <= refresh_tick ? 16'h0 : gap + 16'h1;
        seen <= reset_n && slave_reset_n && (seen || refresh_tick);
    end
    chk_hold_reset: assert property (!slave_reset_n |-> !host_ready && !slave_grant)
        else $error("bus cycle while slave in reset");
    chk_map_top: assert property (top_page_mapped == slave_reset_n)
        else $error("window mapping differs from run state");
    chk_release_cause: assert property (run_release |-> $past(host_io_wr && host_io_addr && host_io_data == 8'h41))
        else $error("slave released without run value");
    chk_reset_cause: assert property ($fell(slave_reset_n) |-> $past(host_io_wr && host_io_addr && host_io_data != 8'h41))
        else $error("slave reset without info write");
    chk_ready_req: assert property (host_ready |-> host_mem_rd || host_mem_wr)
        else $error("ready without request");
    chk_one_owner: assert property (!(host_ready && slave_grant))
        else $error("host and slave own the bus together");
    chk_burst_cap: assert property (hcnt <= 4'h8)
        else $error("more than eight host cycles in a row");
    chk_ready_gap: assert property (host_ready |-> host_turn)
        else $error("host cycle retaken without a turnaround");
    chk_tick_gap: assert property (refresh_tick && seen |-> gap == REFRESH_COUNT - 1)
        else $error("refresh tick spacing wrong");
endmodule
bind slave_board_bringup_loader loader_chk #(.REFRESH_COUNT(REFRESH_COUNT)) u_loader_chk (.*);
`default_nettype wire

/* File: verification/slave_board_bringup_loader_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module slave_board_bringup_loader_tb;
    logic sys_clk = 0, reset_n = 0, ok, slave_mem_rd = 0, slave_mem_wr = 0;
    logic host_io_wr, host_io_addr, host_mem_rd, host_mem_wr, host_ready;
    logic slave_grant, slave_reset_n, refresh_tick, top_page_mapped;
    logic [7:0] host_io_data;
    logic [15:0] host_mem_addr, host_mem_wdata, host_mem_rdata, slave_mem_rdata;
    logic [15:0] slave_mem_addr = 0, slave_mem_wdata = 0, img [16];
    int n_mismatch = 0, checked = 0, i;
    initial forever #50 sys_clk = ~sys_clk;
    host_bfm u_host_bfm (.*);
    slave_board_bringup_loader #(.REFRESH_COUNT(4)) u_slave_board_bringup_loader (.*);
    task automatic cmp(input logic [15:0] got, exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [15:0] a, e);
        u_host_bfm.mem(0, a, 0, 1, ok);
        @(posedge sys_clk) #1 cmp(host_mem_rdata, e);
    endtask
    task automatic slv(input logic w, input logic [15:0] a, v, e);
        int n = 0;
        @(posedge sys_clk) #1 {slave_mem_wr, slave_mem_rd, slave_mem_addr, slave_mem_wdata} = {w, !w, a, v};
        do @(posedge sys_clk); while (slave_grant !== 1'b1 && ++n < 40);
        #1 if (!w) cmp(slave_mem_rdata, e);
        {slave_mem_wr, slave_mem_rd} = 2'b00;
        slave_mem_wdata = ~v;
    endtask
    task automatic stop_test;
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h455f));
        foreach (img[j]) img[j] = 16'($urandom);
        repeat (12) @(posedge sys_clk);
        #1 reset_n = 1;
        u_host_bfm.mem(0, 16'hfff0, 0, 1, ok);
        cmp(16'({slave_reset_n, ok}), 0);
        u_host_bfm.pw(0, 8'h00);
        u_host_bfm.pw(1, 8'h41);
        cmp(16'({slave_reset_n, top_page_mapped}), 3);
        u_host_bfm.pw(0, 8'h0f);
        u_host_bfm.pw(1, 8'h00);
        u_host_bfm.mem(0, 16'hfff0, 0, 1, ok);
        cmp(16'({slave_reset_n, ok}), 2);
        u_host_bfm.pw(0, 8'h00);
        u_host_bfm.mem(1, 16'hfff0, 16'h00f4, 1, ok);
        u_host_bfm.pw(1, 8'h00);
        cmp(16'(slave_reset_n), 0);
        repeat (10) @(posedge sys_clk);
        u_host_bfm.pw(1, 8'h41);
        rdc(16'hfff0, 16'h00f4);
        for (i = 0; i < 16; i++)
            u_host_bfm.mem(1, 16'h0400 + 16'(i), img[i], 1, ok);
        fork
            #600 slv(0, 16'h0400, 0, img[0]);
        join_none
        u_host_bfm.mem(0, 16'h0400, 0, 12, ok);
        wait fork;
        cmp(16'(ok), 1);
        for (i = 0; i < 16; i++)
            rdc(16'h0400 + 16'(i), img[i]);
        u_host_bfm.mem(1, 16'hfff0, 16'h00ea, 1, ok);
        u_host_bfm.pw(1, 8'h00);
        u_host_bfm.pw(1, 8'h41);
        rdc(16'hfff0, 16'h00ea);
        u_host_bfm.mem(1, 16'h0240, img[1], 1, ok);
        rdc(16'h0240, img[1]);
        slv(1, 16'hfff0, 0, 0);
        rdc(16'hfff0, 0);
        u_host_bfm.mem(1, 16'hfff0, 16'h00ff, 1, ok);
        slv(0, 16'hfff0, 0, 16'h00ff);
        stop_test;
    end
    initial
    begin
        #1000000;
        n_mismatch++;
        stop_test;
    end
endmodule
`default_nettype wire
